// ### design/vfe_defines.svh
// Register map, field positions, reset values and timing counts of the video front end control
//
// How it works
// [R01] One of four analog inputs is routed to the luma converter by register.
// [R02] Software changes the input selector only occasionally, never per pixel.
// [R03] In autodetect mode lines per frame are counted and reported in a status bit.
// [R04] The status bit shows 625 lines for the 50 Hz count, else 525 lines.
// [R05] Detected standard picks primary crystal for NTSC/PAL-M, secondary for PAL/SECAM.
// [R06] For PAL-N combination software selects the primary crystal by hand.
// [R07] After a format change software reprograms scaling, cropping and gate delays itself.
// [R08] Luma and chroma overrange flags set when converter input exceeds top reference.
// [R09] Gain loop moves top references until back porch digitizes to the target code.
// [R10] The gain target code is programmable in the converter interface register.
// [R11] Clamp control is generated internally, active during the horizontal sync tip.
// [R12] Reset loads every register default; the default video format is NTSC-M.
// [R13] Strap high during reset puts output clocks and outputs into high impedance.
// [R14] Board supplies the NTSC crystal on primary port, PAL crystal on secondary.
// [R15] The oscillator amplifier of an unused crystal input is switched off; in autodetect mode the code keeps both amplifiers on.
// [R16] Double-rate clock runs at crystal rate, single-rate clock at half of it.
// [R17] Double-rate samples are low-pass filtered and decimated to the single rate.
`ifndef VFE_DEFINES_SVH
`define VFE_DEFINES_SVH

`define ADDR_STATUS        8'h00
`define ADDR_INPUT_FORMAT  8'h01
`define ADDR_CONVERTER_IF  8'h1A
`define ADDR_IRQ_MASK      8'h20

`define INPUT_FORMAT_RESET 8'h11
`define CONVERTER_IF_RESET 8'h38
`define IRQ_MASK_RESET     8'h00
`define GAIN_REF_RESET     8'h80

`define FMT_LSB            0
`define FMT_MSB            2
`define XSEL_LSB           3
`define XSEL_MSB           4
`define MUX_LSB            5
`define MUX_MSB            6

`define ST_LINE_FLAG       0
`define ST_LUMA_OVR        1
`define ST_CHROMA_OVR      2
`define ST_FMT_CHANGE      3
`define ST_SECONDARY       4
`define ST_STICKY_MASK     8'h0E

`define LINE_SPLIT         10'h23F
`define PORCH_DELAY        6'h14

`endif

// ### design/vfe_pkg.sv
// Types shared by the video front end control modules
package vfe_pkg;

   typedef enum logic [2:0] {
      FMT_AUTO,
      FMT_NTSC_M,
      FMT_NTSC_J,
      FMT_PAL,
      FMT_PAL_M,
      FMT_PAL_N,
      FMT_SECAM,
      FMT_PAL_NC
   } video_format_t;

   typedef enum logic [1:0] {
      XSEL_PRIMARY,
      XSEL_SECONDARY,
      XSEL_AUTO,
      XSEL_AUTO_ALT
   } crystal_select_t;

   typedef struct packed {
      logic [7:0] luma;
      logic [7:0] chroma;
   } video_sample_t;

   typedef enum logic [1:0] {
      AGC_IDLE,
      AGC_WAIT_PORCH,
      AGC_DONE
   } agc_state_t;

endpackage

// ### design/line_standard_detector.sv
// Lines-per-frame counter that classifies the incoming standard
`include "vfe_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module line_standard_detector (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic enable,
   input  wire logic line_tick,
   input  wire logic frame_tick,
   output var  logic line_count_format_flag,
   output var  logic format_changed
);

   logic [9:0] line_count_ff;
   logic       flag_ff;
   logic       changed_ff;
   logic       nxt_flag;

   assign line_count_format_flag = flag_ff;
   assign format_changed         = changed_ff;
   assign nxt_flag               = (line_count_ff > `LINE_SPLIT); // R04

   always_ff @(posedge clock) begin
      if (rst || !enable || frame_tick) begin
         line_count_ff <= 10'h000;
      end else if (line_tick && line_count_ff != 10'h3FF) begin
         line_count_ff <= line_count_ff + 10'h001; // R03
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         flag_ff    <= 1'b0;
         changed_ff <= 1'b0;
      end else begin
         changed_ff <= enable && frame_tick && (nxt_flag != flag_ff);
         if (enable && frame_tick) begin
            flag_ff <= nxt_flag; // R03
         end
      end
   end

endmodule

`default_nettype wire

// ### design/oversample_decimator.sv
// Half-band low-pass filter at double rate, decimated to single rate
`timescale 1ns/1ps
`default_nettype none

module oversample_decimator (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  double_tick,
   input  wire logic                  single_tick,
   input  wire vfe_pkg::video_sample_t sample_in,
   output var  vfe_pkg::video_sample_t sample_out,
   output var  logic                  sample_valid
);

   vfe_pkg::video_sample_t tap0_ff;
   vfe_pkg::video_sample_t tap1_ff;
   vfe_pkg::video_sample_t out_ff;
   logic                   valid_ff;

   assign sample_out   = out_ff;
   assign sample_valid = valid_ff;

   // Taps 1-2-1 over a quarter, rounded
   function automatic logic [7:0] lowpass(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      logic [9:0] sum;
      sum = {2'b00, a} + {1'b0, b, 1'b0} + {2'b00, c} + 10'h002;
      return sum[9:2];
   endfunction

   always_ff @(posedge clock) begin
      if (rst) begin
         tap0_ff <= '0;
         tap1_ff <= '0;
      end else if (double_tick) begin
         tap0_ff <= sample_in; // R17
         tap1_ff <= tap0_ff;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         out_ff   <= '0;
         valid_ff <= 1'b0;
      end else begin
         valid_ff <= single_tick;
         if (single_tick) begin
            out_ff.luma   <= lowpass(sample_in.luma, tap0_ff.luma, tap1_ff.luma); // R17
            out_ff.chroma <= lowpass(sample_in.chroma, tap0_ff.chroma, tap1_ff.chroma);
         end
      end
   end

endmodule

`default_nettype wire

// ### design/video_input_frontend_control.sv
// Digital control of the analog video front end: selector, standard detect, clocks, gain, clamp
`include "vfe_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module video_input_frontend_control (
   input  wire logic                   clock,
   input  wire logic                   rst,

   input  wire logic [7:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_write,
   input  wire logic                   reg_read,
   output var  logic [7:0]             reg_rdata,

   input  wire logic                   primary_crystal_port,
   input  wire logic                   secondary_crystal_port,
   input  wire logic                   output_enable_polarity_strap,

   input  wire vfe_pkg::video_sample_t converter_sample,
   input  wire logic                   luma_over_reference,
   input  wire logic                   chroma_over_reference,
   input  wire logic                   sync_tip,
   input  wire logic                   frame_start,

   output var  logic [1:0]             selector_output,
   output var  logic                   luma_clamp,
   output var  logic                   chroma_clamp,
   output var  logic [7:0]             top_reference_level,
   output var  logic                   primary_osc_enable,
   output var  logic                   secondary_osc_enable,

   output var  logic                   double_rate_clock,
   output var  logic                   single_rate_clock,
   output var  logic                   output_drive_enable,
   output var  vfe_pkg::video_sample_t filtered_sample,
   output var  logic                   filtered_valid,
   output var  logic                   irq
);

   // Register state
   logic [7:0]              input_format_config_ff;
   logic [7:0]              converter_interface_config_ff;
   logic [7:0]              irq_mask_ff;
   logic [7:0]              rdata_ff;

   logic                    luma_ovr_ff;
   logic                    chroma_ovr_ff;
   logic                    fmt_change_ff;

   logic                    irq_ff;

   // Front end state
   logic [1:0]              selector_ff;
   logic                    clamp_ff;
   logic [7:0]              gain_ref_ff;
   logic                    use_secondary_ff;

   logic                    primary_osc_ff;
   logic                    secondary_osc_ff;

   logic                    double_tick_ff;
   logic                    single_tick_ff;
   logic                    phase_ff;
   logic                    drive_enable_ff;

   logic                    sync_tip_d_ff;
   logic [5:0]              porch_count_ff;
   vfe_pkg::agc_state_t     agc_state_ff;

   // Derived values
   vfe_pkg::video_format_t  fmt;
   vfe_pkg::crystal_select_t xsel;
   logic                    autodetect;
   logic                    line_flag;
   logic                    format_changed;
   logic                    nxt_use_secondary;

   logic                    crystal_tick;
   logic                    line_tick;
   logic                    write_status;

   logic [7:0]              status_word;
   logic [7:0]              target_code;

   assign fmt         = vfe_pkg::video_format_t'(input_format_config_ff[`FMT_MSB:`FMT_LSB]);
   assign xsel        = vfe_pkg::crystal_select_t'(input_format_config_ff[`XSEL_MSB:`XSEL_LSB]);
   assign autodetect  = (fmt == vfe_pkg::FMT_AUTO);
   assign target_code = converter_interface_config_ff; // R10
   assign line_tick   = sync_tip && !sync_tip_d_ff;
   assign write_status = reg_write && (reg_addr == `ADDR_STATUS);

   // Outputs straight from flip-flops
   assign reg_rdata            = rdata_ff;
   assign selector_output      = selector_ff;
   assign luma_clamp           = clamp_ff;
   assign chroma_clamp         = clamp_ff;
   assign top_reference_level  = gain_ref_ff;

   assign primary_osc_enable   = primary_osc_ff;
   assign secondary_osc_enable = secondary_osc_ff;
   assign double_rate_clock    = double_tick_ff;
   assign single_rate_clock    = single_tick_ff;
   assign output_drive_enable  = drive_enable_ff;

   assign irq                  = irq_ff;

   // Secondary crystal needed for the 625-line standards except PAL-M and PAL-N combination
   function automatic logic wants_secondary(input vfe_pkg::video_format_t f, input logic flag625);
      logic want;
      want = 1'b0;
      case (f)
         vfe_pkg::FMT_AUTO:  want = flag625;
         vfe_pkg::FMT_PAL:   want = 1'b1;
         vfe_pkg::FMT_PAL_N: want = 1'b1;
         vfe_pkg::FMT_SECAM: want = 1'b1;
         default:            want = 1'b0;
      endcase
      return want;
   endfunction

   always_comb begin
      case (xsel)
         vfe_pkg::XSEL_PRIMARY:   nxt_use_secondary = 1'b0;
         vfe_pkg::XSEL_SECONDARY: nxt_use_secondary = 1'b1;
         default:                 nxt_use_secondary = wants_secondary(fmt, line_flag); // R05
      endcase
   end

   always_comb begin
      status_word                = 8'h00;
      status_word[`ST_LINE_FLAG]  = line_flag; // R03
      status_word[`ST_LUMA_OVR]   = luma_ovr_ff;
      status_word[`ST_CHROMA_OVR] = chroma_ovr_ff;
      status_word[`ST_FMT_CHANGE] = fmt_change_ff;
      status_word[`ST_SECONDARY]  = use_secondary_ff;
   end

   assign crystal_tick = use_secondary_ff ? secondary_crystal_port : primary_crystal_port;

   line_standard_detector u_detector (
      .clock                  (clock),
      .rst                    (rst),
      .enable                 (autodetect),
      .line_tick              (line_tick),
      .frame_tick             (frame_start),
      .line_count_format_flag (line_flag),
      .format_changed         (format_changed)
   );

   oversample_decimator u_decimator (
      .clock        (clock),
      .rst          (rst),
      .double_tick  (double_tick_ff),
      .single_tick  (single_tick_ff),
      .sample_in    (converter_sample),
      .sample_out   (filtered_sample),
      .sample_valid (filtered_valid)
   );

   // Configuration registers
   always_ff @(posedge clock) begin
      if (rst) begin
         input_format_config_ff        <= `INPUT_FORMAT_RESET; // R12
         converter_interface_config_ff <= `CONVERTER_IF_RESET; // R09
         irq_mask_ff                   <= `IRQ_MASK_RESET;
      end else if (reg_write) begin
         if (reg_addr == `ADDR_INPUT_FORMAT) begin
            input_format_config_ff <= {1'b0, reg_wdata[6:0]};
         end else if (reg_addr == `ADDR_CONVERTER_IF) begin
            converter_interface_config_ff <= reg_wdata; // R10
         end else if (reg_addr == `ADDR_IRQ_MASK) begin
            irq_mask_ff <= reg_wdata & `ST_STICKY_MASK;
         end
      end
   end

   // Read data one cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (reg_read) begin
         if (reg_addr == `ADDR_STATUS) begin
            rdata_ff <= status_word;
         end else if (reg_addr == `ADDR_INPUT_FORMAT) begin
            rdata_ff <= input_format_config_ff;
         end else if (reg_addr == `ADDR_CONVERTER_IF) begin
            rdata_ff <= converter_interface_config_ff;
         end else if (reg_addr == `ADDR_IRQ_MASK) begin
            rdata_ff <= irq_mask_ff;
         end else begin
            rdata_ff <= 8'h00;
         end
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   // Sticky flags, write one to clear, set wins
   always_ff @(posedge clock) begin
      if (rst) begin
         luma_ovr_ff   <= 1'b0;
         chroma_ovr_ff <= 1'b0;
         fmt_change_ff <= 1'b0;
      end else begin
         luma_ovr_ff   <= luma_over_reference ||
                          (luma_ovr_ff && !(write_status && reg_wdata[`ST_LUMA_OVR])); // R08
         chroma_ovr_ff <= chroma_over_reference ||
                          (chroma_ovr_ff && !(write_status && reg_wdata[`ST_CHROMA_OVR])); // R08
         fmt_change_ff <= format_changed ||
                          (fmt_change_ff && !(write_status && reg_wdata[`ST_FMT_CHANGE]));
      end
   end

   // Level interrupt
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(status_word & irq_mask_ff & `ST_STICKY_MASK);
      end
   end

   // Input selector, changed only on register writes
   always_ff @(posedge clock) begin
      if (rst) begin
         selector_ff <= 2'h0;
      end else begin
         selector_ff <= input_format_config_ff[`MUX_MSB:`MUX_LSB]; // R01 R02
      end
   end

   // Crystal source and oscillator enables
   always_ff @(posedge clock) begin
      if (rst) begin
         use_secondary_ff <= 1'b0;
      end else begin
         use_secondary_ff <= nxt_use_secondary; // R05
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         primary_osc_ff   <= 1'b1;
         secondary_osc_ff <= 1'b0;
      end else begin
         primary_osc_ff   <= !nxt_use_secondary || autodetect; // R15
         secondary_osc_ff <= nxt_use_secondary || autodetect; // R15
      end
   end

   // Double rate at crystal rate, single rate every second tick
   always_ff @(posedge clock) begin
      if (rst) begin
         double_tick_ff <= 1'b0;
         single_tick_ff <= 1'b0;
      end else begin
         double_tick_ff <= crystal_tick; // R16
         single_tick_ff <= crystal_tick && phase_ff; // R16
      end
   end

   // Tick parity
   always_ff @(posedge clock) begin
      if (rst) begin
         phase_ff <= 1'b0;
      end else if (crystal_tick) begin
         phase_ff <= !phase_ff;
      end
   end

   // Outputs float while strap high under reset
   always_ff @(posedge clock) begin
      if (rst) begin
         drive_enable_ff <= !output_enable_polarity_strap; // R13
      end else begin
         drive_enable_ff <= 1'b1;
      end
   end

   // Clamp on the sync tip
   always_ff @(posedge clock) begin
      if (rst) begin
         clamp_ff <= 1'b0;
      end else begin
         clamp_ff <= sync_tip; // R11
      end
   end

   // Sync tip delayed for edges
   always_ff @(posedge clock) begin
      if (rst) begin
         sync_tip_d_ff <= 1'b0;
      end else begin
         sync_tip_d_ff <= sync_tip;
      end
   end

   // Gain loop: sample back porch a fixed count of single ticks after sync tip
   always_ff @(posedge clock) begin
      if (rst) begin
         agc_state_ff   <= vfe_pkg::AGC_IDLE;
         porch_count_ff <= 6'h00;
         gain_ref_ff    <= `GAIN_REF_RESET;
      end else begin
         case (agc_state_ff)
            vfe_pkg::AGC_IDLE: begin
               if (!sync_tip && sync_tip_d_ff) begin
                  agc_state_ff   <= vfe_pkg::AGC_WAIT_PORCH;
                  porch_count_ff <= 6'h00;
               end
            end

            vfe_pkg::AGC_WAIT_PORCH: begin
               if (sync_tip) begin
                  agc_state_ff <= vfe_pkg::AGC_IDLE;
               end else if (single_tick_ff) begin
                  if (porch_count_ff == `PORCH_DELAY) begin
                     agc_state_ff <= vfe_pkg::AGC_DONE;
                     if (filtered_sample.luma > target_code && gain_ref_ff != 8'hFF) begin
                        gain_ref_ff <= gain_ref_ff + 8'h01; // R09
                     end else if (filtered_sample.luma < target_code && gain_ref_ff != 8'h00) begin
                        gain_ref_ff <= gain_ref_ff - 8'h01; // R09
                     end
                  end else begin
                     porch_count_ff <= porch_count_ff + 6'h01;
                  end
               end
            end

            vfe_pkg::AGC_DONE: begin
               if (sync_tip) begin
                  agc_state_ff <= vfe_pkg::AGC_IDLE;
               end
            end

            default: agc_state_ff <= vfe_pkg::AGC_IDLE;
         endcase
      end
   end

endmodule

`default_nettype wire

// ### verif/video_input_frontend_control_assertions.sv
// Port-level assertions for the video front end control
`timescale 1ns/1ps
`default_nettype none

module frontend_checker (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       reg_read,
   input wire logic       reg_write,
   input wire logic [7:0] reg_rdata,
   input wire logic       primary_crystal_port,
   input wire logic       output_enable_polarity_strap,
   input wire logic       sync_tip,
   input wire logic [1:0] selector_output,
   input wire logic       luma_clamp,
   input wire logic       chroma_clamp,
   input wire logic [7:0] top_reference_level,
   input wire logic       primary_osc_enable,
   input wire logic       secondary_osc_enable,
   input wire logic       double_rate_clock,
   input wire logic       single_rate_clock,
   input wire logic       output_drive_enable,
   input wire logic       filtered_valid,
   input wire logic       irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   a_reset_defaults: assert property (disable iff (1'b0) rst |=> selector_output == 2'h0 && !irq
      && top_reference_level == 8'h80 && primary_osc_enable && !secondary_osc_enable && reg_rdata == 8'h00)
      else $error("reset defaults missing");
   a_strap_float: assert property (disable iff (1'b0) rst && output_enable_polarity_strap |=> !output_drive_enable)
      else $error("outputs driven under strap");
   a_drive_after: assert property (disable iff (1'b0) !rst |=> output_drive_enable)
      else $error("outputs not driven");
   a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_select_by_write: assert property ($changed(selector_output) |-> $past(reg_write) || $past(reg_write, 2))
      else $error("selector moved without write");
   a_clamp_on: assert property (sync_tip |=> luma_clamp && chroma_clamp)
      else $error("clamp missing in sync tip");
   a_clamp_off: assert property (!sync_tip |=> !luma_clamp && !chroma_clamp)
      else $error("clamp outside sync tip");
   a_unused_osc: assert property (double_rate_clock && !$past(secondary_osc_enable)
      && !$past(secondary_osc_enable, 2) |-> $past(primary_crystal_port)) else $error("tick from idle crystal");
   a_half_rate: assert property (single_rate_clock |-> double_rate_clock ##1 !single_rate_clock)
      else $error("single rate not half of double rate");
   a_decimate_out: assert property (single_rate_clock |=> filtered_valid)
      else $error("no filtered sample after single tick");
   a_valid_cause: assert property (filtered_valid |-> $past(single_rate_clock))
      else $error("filtered sample without single tick");
   a_gain_step: assert property (!$past(rst) && $changed(top_reference_level) |-> !sync_tip &&
      (top_reference_level == $past(top_reference_level) + 8'h01
      || top_reference_level == $past(top_reference_level) - 8'h01)) else $error("gain step not one code");
endmodule

bind video_input_frontend_control frontend_checker chk (.*);

`default_nettype wire

// ### verif/video_source_model.sv
// Behavioural model of the video sources and the two crystals
`timescale 1ns/1ps
`default_nettype none

module video_source_model (
   input  wire logic                   clock,
   input  wire logic [7:0]             line_len,
   input  wire logic [9:0]             lines_per_frame,
   input  wire logic [7:0]             luma_level,
   input  wire logic [7:0]             chroma_level,
   output wire logic                   primary_crystal_port,
   output wire logic                   secondary_crystal_port,
   output wire vfe_pkg::video_sample_t converter_sample,
   output wire logic                   luma_over_reference,
   output wire logic                   chroma_over_reference,
   output wire logic                   sync_tip,
   output wire logic                   frame_start
);
   logic [1:0] prim_cnt = 2'h0;
   logic [1:0] sec_cnt  = 2'h0;
   logic [7:0] pix_cnt  = 8'h00;
   logic [9:0] line_cnt = 10'h000;

   // Primary period 4, secondary 3: roughly the crystal ratio
   assign primary_crystal_port   = (prim_cnt == 2'h0);
   assign secondary_crystal_port = (sec_cnt == 2'h0);
   assign sync_tip               = (pix_cnt < 8'h02);
   assign frame_start            = (pix_cnt == 8'h00) && (line_cnt == 10'h000);
   assign converter_sample       = {luma_level, chroma_level};
   assign luma_over_reference    = (luma_level == 8'hFF);
   assign chroma_over_reference  = (chroma_level == 8'hFF);

   always @(posedge clock) begin
      prim_cnt <= prim_cnt + 2'h1;
      sec_cnt <= (sec_cnt == 2'h2) ? 2'h0 : sec_cnt + 2'h1;
      if (pix_cnt >= line_len - 8'h01) begin
         pix_cnt <= 8'h00;
         line_cnt <= (line_cnt >= lines_per_frame - 10'h001) ? 10'h000 : line_cnt + 10'h001;
      end else begin
         pix_cnt <= pix_cnt + 8'h01;
      end
   end
endmodule

`default_nettype wire

// ### verif/video_input_frontend_control_test.sv
// Self-checking bench for the video front end control
`include "vfe_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module video_input_frontend_control_test;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic       output_enable_polarity_strap = 1'b1;
   logic [7:0] line_len = 8'h04;
   logic [9:0] lines_per_frame = 10'h258;
   logic [7:0] luma_level = 8'h38;
   logic [7:0] chroma_level = 8'h40;
   logic       flat = 1'b0;
   logic       rd_seen = 1'b0;
   logic       sec;
   logic [31:0] rnd;
   logic [7:0] exp_q[$];
   int         fails = 0;
   int         total_checks = 0;
   int         cycles = 0;
   int         seed = 26;
   wire logic  primary_crystal_port, secondary_crystal_port, luma_over_reference, chroma_over_reference;
   wire logic  sync_tip, frame_start, luma_clamp, chroma_clamp, primary_osc_enable, secondary_osc_enable;
   wire logic  double_rate_clock, single_rate_clock, output_drive_enable, filtered_valid, irq;
   wire logic [7:0] reg_rdata, top_reference_level;
   wire logic [1:0] selector_output;
   wire vfe_pkg::video_sample_t converter_sample, filtered_sample;

   video_source_model far (.*);

   video_input_frontend_control uut (.*);

   initial begin
      forever #50 clock = ~clock;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rises(input int n);
      repeat (n) @(posedge sync_tip);
      @(posedge clock);
   endtask

   task automatic frames(input int n);
      repeat (n) @(posedge frame_start);
      cyc(5);
   endtask

   // Twenty doubles span 20 * per clocks and hold ten singles
   task automatic rate(input int per);
      int d = 0;
      int s = 0;
      int c = 0;
      while (d < 21) begin
         @(posedge clock);
         if (d > 0) c++;
         if (double_rate_clock === 1'b1) begin
            d++;
            if (d <= 20 && single_rate_clock === 1'b1) s++;
         end
      end
      check(8'(c), 8'(20 * per));
      check(8'(s), 8'h0A);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (rd_seen) check(reg_rdata, exp_q.pop_front());
      if (flat && filtered_valid === 1'b1) check(filtered_sample.luma, luma_level);
      rd_seen <= reg_read;
      if (cycles == 40000) begin
         fails++;
         conclude();
      end
   end

   initial begin
      cyc(16);
      check(output_drive_enable, 8'h00);
      rst <= 1'b0;
      output_enable_polarity_strap <= 1'b0;
      cyc(2);
      check(output_drive_enable, 8'h01);
      check(top_reference_level, 8'h80);
      rd(`ADDR_INPUT_FORMAT, 8'h11);
      rd(`ADDR_CONVERTER_IF, 8'h38);
      rd(`ADDR_IRQ_MASK, 8'h00);
      rd(`ADDR_STATUS, 8'h00);
      rd(8'h55, 8'h00);
      rnd = $random(seed);
      chroma_level <= {1'b0, rnd[14:8]};
      wr(`ADDR_CONVERTER_IF, rnd[7:0]);
      rd(`ADDR_CONVERTER_IF, rnd[7:0]);
      for (int i = 0; i < 4; i++) begin
         wr(`ADDR_INPUT_FORMAT, {1'b1, 2'(i), 5'h01});
         cyc(2);
         check(8'(selector_output), 8'(i));
         rd(`ADDR_INPUT_FORMAT, {1'b0, 2'(i), 5'h01});
      end
      for (int i = 1; i < 9; i++) begin
         sec = (i == 3 || i == 5 || i == 6 || i == 8);
         wr(`ADDR_INPUT_FORMAT, (i == 8) ? 8'h09 : 8'(8'h10 + i));
         cyc(3);
         check(8'(secondary_osc_enable), {7'h00, sec});
         rd(`ADDR_STATUS, {3'h0, sec, 4'h0});
         if (i < 4) rate((i == 3) ? 3 : 4);
      end
      wr(`ADDR_INPUT_FORMAT, 8'h11);
      luma_level <= 8'hFF;
      cyc(4);
      luma_level <= 8'h38;
      cyc(4);
      check(8'(irq), 8'h00);
      rd(`ADDR_STATUS, 8'h02);
      wr(`ADDR_IRQ_MASK, 8'hFF);
      rd(`ADDR_IRQ_MASK, 8'h0E);
      check(8'(irq), 8'h01);
      chroma_level <= 8'hFF;
      cyc(4);
      chroma_level <= 8'h40;
      cyc(4);
      rd(`ADDR_STATUS, 8'h06);
      wr(`ADDR_STATUS, 8'h06);
      cyc(2);
      check(8'(irq), 8'h00);
      wr(`ADDR_INPUT_FORMAT, 8'h10);
      frames(3);
      rd(`ADDR_STATUS, 8'h19);
      check(8'(secondary_osc_enable), 8'h01);
      wr(`ADDR_STATUS, 8'h08);
      lines_per_frame <= 10'h20D;
      frames(3);
      rd(`ADDR_STATUS, 8'h08);
      rd(`ADDR_INPUT_FORMAT, 8'h10);
      luma_level <= 8'h50;
      line_len <= 8'hF0;
      rst <= 1'b1;
      cyc(2);
      @(negedge sync_tip);
      @(posedge clock);
      rst <= 1'b0;
      cyc(2);
      check(top_reference_level, 8'h80);
      check(8'(output_drive_enable), 8'h01);
      rd(`ADDR_INPUT_FORMAT, 8'h11);
      cyc(40);
      flat <= 1'b1;
      rises(4);
      check(top_reference_level, 8'h83);
      wr(`ADDR_CONVERTER_IF, 8'h60);
      rises(2);
      check(top_reference_level, 8'h81);
      conclude();
   end
endmodule

`default_nettype wire
